//--- hw/dtr_cfg.svh
// Operation
// - Reset: idle, controls cleared, counters and loads FFFF.
// - Reset: both prescale registers start at zero.
// - Configuration 0 joined timer, 1 real-time clock.
// - Configuration 4 gives two independent 16-bit halves.
// - Joined write splits load into both halves.
// - Joined read returns second:first half counts.
// - Joined timer obeys only first half mode.
// - Joined timer reloads concatenated load after zero.
// - One-shot stops and clears enable; periodic continues.
// - Zero sets sticky time-out flag and trigger.
// - Load rewrite while running reloads counter next cycle.
// - Stall enable freezes count during debug halt.
// - First real-time selection loads count of one.
// - Slow clock divided to one-second counting tick.
// - Real-time match rolls count to zero, continues.
// - Match sets sticky clock-match flag, cleared by software.
// - Clock enable overrides stall during debug halt.
// - Split halves count down with 8-bit prescaler.
// - Half at zero reloads count and prescale.
// - Prescale P gives one step per P+1 clocks.
`ifndef DTR_CFG_SVH
`define DTR_CFG_SVH

`define DT_OFF_CFG 8'h00
`define DT_OFF_MODEA 8'h04
`define DT_OFF_MODEB 8'h08
`define DT_OFF_CTL 8'h0C
`define DT_OFF_IMR 8'h18
`define DT_OFF_RIS 8'h1C
`define DT_OFF_MIS 8'h20
`define DT_OFF_ICR 8'h24
`define DT_OFF_ILRA 8'h28
`define DT_OFF_ILRB 8'h2C
`define DT_OFF_MATCHA 8'h30
`define DT_OFF_PRA 8'h38
`define DT_OFF_PRB 8'h3C
`define DT_OFF_CNTA 8'h48
`define DT_OFF_CNTB 8'h4C

`define DT_CFG_JOIN 3'h0
`define DT_CFG_RTC 3'h1
`define DT_CFG_SPLIT 3'h4
`define DT_MODE_ONESHOT 2'h1
`define DT_MODE_PERIODIC 2'h2

`define DT_CNT_RST 16'hFFFF
`define DT_PS_RST 8'h00
`define DT_ZERO16 16'h0000
`define DT_ONE16 16'h0001
`define DT_ONE8 8'h01
`define DT_ZERO32 32'h0000_0000
`define DT_ONE32 32'h0000_0001
`define DT_RTC_FIRST 32'h0000_0001
`define DT_CTL_MASK 16'h0313
`define DT_STAT_MASK 16'h0109

`define DT_RTC_IN_HZ 32768
`define DT_TICK_HZ 1
`define DT_RTC_DIV (`DT_RTC_IN_HZ / `DT_TICK_HZ)
`define DT_DIV_ONE 16'h0001

`endif

//--- hw/dtr_pkg.sv
package dtr_pkg;

  // Control register layout.
  typedef struct packed {
    logic [5:0] rsvHi;
    logic stallB;
    logic enB;
    logic [2:0] rsvMid;
    logic clock_mode_enable_bit;
    logic [1:0] rsvLo;
    logic stallA;
    logic enA;
  } dtr_ctl_t;

  // Status, mask and clear register layout.
  typedef struct packed {
    logic [6:0] rsvHi;
    logic toB;
    logic [3:0] rsvMid;
    logic rtcMatch;
    logic [1:0] rsvLo;
    logic toA;
  } dtr_stat_t;

  // Result of one step of a 16-bit half.
  typedef struct packed {
    logic hit;
    logic [7:0] ps;
    logic [15:0] cnt;
  } dtr_step_t;

endpackage

//--- hw/dtr_timer.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "dtr_cfg.svh"

module dtr_timer #(
  parameter int unsigned RTC_DIV = `DT_RTC_DIV
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Debug halt from the processor, same clock.
  input wire logic dbgHalt,
  // Slow real-time clock pin.
  input wire logic rtcClkIn,
  // Interrupt and time-out triggers.
  output logic irqOut,
  output logic trigA,
  output logic trigB
);

  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------

  logic [2:0] cfg_ff;
  logic [1:0] modeA_ff;
  logic [1:0] modeB_ff;
  dtr_pkg::dtr_ctl_t ctl_ff;
  dtr_pkg::dtr_stat_t imr_ff;
  dtr_pkg::dtr_stat_t ris_ff;
  logic [15:0] ilrA_ff;
  logic [15:0] ilrB_ff;
  logic [15:0] cntA_ff;
  logic [15:0] cntB_ff;
  logic [31:0] matchA_ff;
  logic [7:0] prA_ff;
  logic [7:0] prB_ff;
  logic [7:0] psA_ff;
  logic [7:0] psB_ff;
  logic rtcSeen_ff;

  logic [15:0] nxt_cntA;
  logic [15:0] nxt_cntB;
  logic [7:0] nxt_psA;
  logic [7:0] nxt_psB;
  logic toA;
  logic toB;
  logic rtcHit;
  logic runA;
  logic runB;
  logic rtcRun;
  logic join32;
  logic [31:0] cnt32;
  logic [31:0] rdMux;
  dtr_pkg::dtr_step_t stepA;
  dtr_pkg::dtr_step_t stepB;
  dtr_pkg::dtr_stat_t setStat;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------

  // True when this cycle writes the given offset.
  function automatic logic wrOn(input logic [7:0] off);
    return regWr && (regAddr == off);
  endfunction

  // One clock of a 16-bit half with its prescaler.
  function automatic dtr_pkg::dtr_step_t step16(
    input logic run,
    input logic [15:0] cnt,
    input logic [7:0] ps,
    input logic [7:0] pr,
    input logic [15:0] ilr
  );
    dtr_pkg::dtr_step_t s;
    s.hit = 1'b0;
    s.ps = ps;
    s.cnt = cnt;
    if (run) begin
      if (ps != `DT_PS_RST) begin
        s.ps = ps - `DT_ONE8;
      end else if (cnt == `DT_ZERO16) begin
        s.hit = 1'b1;
        s.cnt = ilr;
        s.ps = pr;
      end else begin
        s.cnt = cnt - `DT_ONE16;
        s.ps = pr;
      end
    end
    return s;
  endfunction

  // ----------------------------------------------------------
  // Slow clock divider
  // ----------------------------------------------------------

  logic rtcSync1_ff;
  logic rtcSync2_ff;
  logic rtcPrev_ff;
  logic [15:0] divCnt_ff;
  logic rtcTick_ff;

  // Two-stage synchroniser for the slow clock pin.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rtcSync1_ff <= 1'b0;
      rtcSync2_ff <= 1'b0;
      rtcPrev_ff <= 1'b0;
    end else begin
      rtcSync1_ff <= rtcClkIn;
      rtcSync2_ff <= rtcSync1_ff;
      rtcPrev_ff <= rtcSync2_ff;
    end
  end

  // Counts slow rising edges into a one-second tick pulse.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      divCnt_ff <= '0;
      rtcTick_ff <= 1'b0;
    end else if (cfg_ff != `DT_CFG_RTC || !ctl_ff.enA) begin
      divCnt_ff <= '0;
      rtcTick_ff <= 1'b0;
    end else begin
      rtcTick_ff <= 1'b0;
      if (rtcSync2_ff && !rtcPrev_ff) begin
        if (divCnt_ff == 16'(RTC_DIV - 1)) begin
          divCnt_ff <= '0;
          rtcTick_ff <= 1'b1;
        end else begin
          divCnt_ff <= divCnt_ff + `DT_DIV_ONE;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Counting
  // ----------------------------------------------------------

  // Both joined modes concatenate the halves.
  assign join32 = (cfg_ff == `DT_CFG_JOIN) || (cfg_ff == `DT_CFG_RTC);
  assign cnt32 = {cntB_ff, cntA_ff};

  assign runA = ctl_ff.enA && !(dbgHalt && ctl_ff.stallA);
  assign runB = ctl_ff.enB && !(dbgHalt && ctl_ff.stallB);
  assign rtcRun = ctl_ff.enA && rtcTick_ff
    && (ctl_ff.clock_mode_enable_bit || !(dbgHalt && (ctl_ff.stallA || ctl_ff.stallB)));

  assign stepA = step16(runA, cntA_ff, psA_ff, prA_ff, ilrA_ff);
  assign stepB = step16(runB, cntB_ff, psB_ff, prB_ff, ilrB_ff);

  // Next count for the selected configuration.
  always_comb begin
    nxt_cntA = cntA_ff;
    nxt_cntB = cntB_ff;
    nxt_psA = psA_ff;
    nxt_psB = psB_ff;
    toA = 1'b0;
    toB = 1'b0;
    rtcHit = 1'b0;
    unique case (cfg_ff)
      `DT_CFG_JOIN: begin
        if (runA) begin
          if (cnt32 == `DT_ZERO32) begin
            toA = 1'b1;
            {nxt_cntB, nxt_cntA} = {ilrB_ff, ilrA_ff};
          end else begin
            {nxt_cntB, nxt_cntA} = cnt32 - `DT_ONE32;
          end
        end
      end
      `DT_CFG_RTC: begin
        if (rtcRun) begin
          if (cnt32 == matchA_ff) begin
            rtcHit = 1'b1;
            {nxt_cntB, nxt_cntA} = `DT_ZERO32;
          end else begin
            {nxt_cntB, nxt_cntA} = cnt32 + `DT_ONE32;
          end
        end
      end
      default: begin
        nxt_cntA = stepA.cnt;
        nxt_psA = stepA.ps;
        toA = stepA.hit;
        nxt_cntB = stepB.cnt;
        nxt_psB = stepB.ps;
        toB = stepB.hit;
      end
    endcase
    if (wrOn(`DT_OFF_ILRA)) begin
      if (cfg_ff == `DT_CFG_JOIN) begin
        {nxt_cntB, nxt_cntA} = regWdata;
      end else if (!join32) begin
        nxt_cntA = regWdata[15:0];
        nxt_psA = prA_ff;
      end
    end
    if (wrOn(`DT_OFF_ILRB) && !join32) begin
      nxt_cntB = regWdata[15:0];
      nxt_psB = prB_ff;
    end
    if (wrOn(`DT_OFF_CFG) && regWdata[2:0] == `DT_CFG_RTC
        && !rtcSeen_ff) begin
      {nxt_cntB, nxt_cntA} = `DT_RTC_FIRST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cntA_ff <= `DT_CNT_RST;
      cntB_ff <= `DT_CNT_RST;
    end else begin
      cntA_ff <= nxt_cntA;
      cntB_ff <= nxt_cntB;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      psA_ff <= `DT_PS_RST;
      psB_ff <= `DT_PS_RST;
    end else begin
      psA_ff <= nxt_psA;
      psB_ff <= nxt_psB;
    end
  end

  // Remembers that the clock mode has been chosen once.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rtcSeen_ff <= 1'b0;
    end else if (wrOn(`DT_OFF_CFG)
                 && regWdata[2:0] == `DT_CFG_RTC) begin
      rtcSeen_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------

  // Configuration, mode fields, prescale and match.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_ff <= `DT_CFG_JOIN;
      modeA_ff <= '0;
      modeB_ff <= '0;
      prA_ff <= `DT_PS_RST;
      prB_ff <= `DT_PS_RST;
      matchA_ff <= `DT_ZERO32;
    end else begin
      if (wrOn(`DT_OFF_CFG)) begin
        cfg_ff <= regWdata[2:0];
      end
      if (wrOn(`DT_OFF_MODEA)) begin
        modeA_ff <= regWdata[1:0];
      end
      if (wrOn(`DT_OFF_MODEB)) begin
        modeB_ff <= regWdata[1:0];
      end
      if (wrOn(`DT_OFF_PRA)) begin
        prA_ff <= regWdata[7:0];
      end
      if (wrOn(`DT_OFF_PRB)) begin
        prB_ff <= regWdata[7:0];
      end
      if (wrOn(`DT_OFF_MATCHA)) begin
        matchA_ff <= regWdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ilrA_ff <= `DT_CNT_RST;
      ilrB_ff <= `DT_CNT_RST;
    end else begin
      if (wrOn(`DT_OFF_ILRA)) begin
        ilrA_ff <= regWdata[15:0];
        if (join32) begin
          ilrB_ff <= regWdata[31:16];
        end
      end else if (wrOn(`DT_OFF_ILRB)) begin
        ilrB_ff <= regWdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl_ff <= '0;
    end else if (wrOn(`DT_OFF_CTL)) begin
      ctl_ff <= dtr_pkg::dtr_ctl_t'(regWdata[15:0] & `DT_CTL_MASK);
    end else begin
      if (toA && modeA_ff == `DT_MODE_ONESHOT) begin
        ctl_ff.enA <= 1'b0;
      end
      if (toB && modeB_ff == `DT_MODE_ONESHOT) begin
        ctl_ff.enB <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------

  // Events of this cycle in status layout.
  always_comb begin
    setStat = '0;
    setStat.toA = toA;
    setStat.toB = toB;
    setStat.rtcMatch = rtcHit;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ris_ff <= '0;
    end else if (wrOn(`DT_OFF_ICR)) begin
      ris_ff <= dtr_pkg::dtr_stat_t'((ris_ff & ~regWdata[15:0])
                                     | setStat);
    end else begin
      ris_ff <= dtr_pkg::dtr_stat_t'(ris_ff | setStat);
    end
  end

  // Interrupt mask register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      imr_ff <= '0;
    end else if (wrOn(`DT_OFF_IMR)) begin
      imr_ff <= dtr_pkg::dtr_stat_t'(regWdata[15:0] & `DT_STAT_MASK);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(ris_ff & imr_ff);
    end
  end

  // Trigger pulses one cycle after each time-out.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trigA <= 1'b0;
      trigB <= 1'b0;
    end else begin
      trigA <= toA;
      trigB <= toB;
    end
  end

  // ----------------------------------------------------------
  // Read port
  // ----------------------------------------------------------

  // Selects read data; unmapped offsets read zero.
  always_comb begin
    rdMux = '0;
    unique case (regAddr)
      `DT_OFF_CFG: rdMux = {29'h0, cfg_ff};
      `DT_OFF_MODEA: rdMux = {30'h0, modeA_ff};
      `DT_OFF_MODEB: rdMux = {30'h0, modeB_ff};
      `DT_OFF_CTL: rdMux = {16'h0, ctl_ff};
      `DT_OFF_IMR: rdMux = {16'h0, imr_ff};
      `DT_OFF_RIS: rdMux = {16'h0, ris_ff};
      `DT_OFF_MIS: rdMux = {16'h0, ris_ff & imr_ff};
      `DT_OFF_ILRA: begin
        rdMux = join32 ? {ilrB_ff, ilrA_ff} : {16'h0, ilrA_ff};
      end
      `DT_OFF_ILRB: rdMux = {16'h0, ilrB_ff};
      `DT_OFF_MATCHA: rdMux = matchA_ff;
      `DT_OFF_PRA: rdMux = {24'h0, prA_ff};
      `DT_OFF_PRB: rdMux = {24'h0, prB_ff};
      `DT_OFF_CNTA: begin
        rdMux = join32 ? cnt32 : {16'h0, cntA_ff};
      end
      `DT_OFF_CNTB: rdMux = {16'h0, cntB_ff};
      default: rdMux = '0;
    endcase
  end

  // Read data stands for one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  reset_counts_a:
    assert property ($past(reset) |->
      cntA_ff == `DT_CNT_RST && ilrB_ff == `DT_CNT_RST
      && ctl_ff == '0)
    else $error("Counters or loads wrong after reset.");

  reset_prescale_a:
    assert property ($past(reset) |-> psA_ff == `DT_PS_RST
      && psB_ff == `DT_PS_RST)
    else $error("Prescale not zero after reset.");

  rtc_first_load_a:
    assert property (wrOn(`DT_OFF_CFG) && !rtcSeen_ff
      && regWdata[2:0] == `DT_CFG_RTC |=> cnt32 == `DT_RTC_FIRST)
    else $error("First clock selection did not load one.");

  load_split_a:
    assert property (wrOn(`DT_OFF_ILRA) && join32 |=>
      ilrB_ff == $past(regWdata[31:16]))
    else $error("Joined load write lost upper half.");

  oneshot_stop_a:
    assert property (toA && modeA_ff == `DT_MODE_ONESHOT
      && !regWr |=> !ctl_ff.enA)
    else $error("One-shot did not clear its enable.");

  timeout_sticky_a:
    assert property (toA |=> ris_ff.toA ##1 ris_ff.toA
      || $past(wrOn(`DT_OFF_ICR)))
    else $error("Time-out flag not held.");

  stall_hold_a:
    assert property (cfg_ff != `DT_CFG_RTC && dbgHalt
      && ctl_ff.stallA && !regWr |=> $stable(cntA_ff))
    else $error("Stalled half kept counting.");

  rtc_rollover_a:
    assert property (rtcHit && !regWr |=> cnt32 == `DT_ZERO32
      && ris_ff.rtcMatch)
    else $error("Clock match did not roll over.");

  irq_follow_a:
    assert property (|(ris_ff & imr_ff) |=> irqOut)
    else $error("Interrupt missing for masked flag.");

  read_joined_a:
    assert property (regRd && regAddr == `DT_OFF_CNTA && join32
      |=> regRdata == $past(cnt32) ##1 regRdata == '0
      || $past(regRd))
    else $error("Joined count read wrong.");

  periodic_wrap_c: cover property (toA
    && modeA_ff == `DT_MODE_PERIODIC ##[1:20] toA);
  split_both_c: cover property (toA && toB);
  rtc_match_c: cover property (rtcHit);

endmodule

//--- dv/dtr_timer_tb.sv
`timescale 1ns/100ps
`include "dtr_cfg.svh"

module dtr_timer_tb;

  // ----------------------------------------------------------
  // Stimulus signals and the timer under test.
  // ----------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic dbgHalt = 1'b0;
  logic rtcClkIn = 1'b0;
  logic rtcOn = 1'b0;
  logic irqOut;
  logic trigA;
  logic trigB;
  int errTotal = 0;
  int checkCount = 0;
  int n;
  logic [31:0] rv;
  logic [31:0] rv2;
  logic [7:0] rstAddr [10] = '{8'h48, 8'h28, 8'h4C, 8'h2C, 8'h38, 8'h3C,
    8'h00, 8'h0C, 8'h1C, 8'h7C};
  logic [31:0] rstVal [10] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
    32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic [7:0] psTab [3] = '{8'h00, 8'h02, 8'hFF};
  logic [15:0] ldTab [3] = '{16'h0005, 16'h0003, 16'h0001};

  // The slow clock divider is shortened to four edges per tick.
  dtr_timer #(.RTC_DIV(4)) u_dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .dbgHalt(dbgHalt),
    .rtcClkIn(rtcClkIn),
    .irqOut(irqOut),
    .trigA(trigA),
    .trigB(trigB)
  );

  // System clock at 200 MHz.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Slow clock toggles only while the clock scenario runs.
  // scaled slow clock
  initial begin
    forever begin
      #20;
      if (rtcOn) begin
        rtcClkIn = ~rtcClkIn;
      end
    end
  end

  // ----------------------------------------------------------
  // Bus tasks and comparison helpers.
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  // Counts edges until the chosen trigger is seen, bounded.
  task automatic waitTrig(input logic useB, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (((useB ? trigB : trigA) !== 1'b1) && cnt < 3000);
  endtask

  task automatic endSim;
    $display("Checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short after about 40000 cycles.
  initial begin
    #200000;
    errTotal++;
    $display("BAD watchdog expected finish seen hang");
    endSim();
  end

  // ----------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk("outputs", 32'h0000_0000, {29'h0, irqOut, trigA, trigB});
    for (int i = 0; i < 10; i++) begin
      rdChk("reset value", rstAddr[i], rstVal[i]);
    end
    wr(`DT_OFF_MODEA, 32'h0000_0001);
    wr(`DT_OFF_MODEB, 32'h0000_0002);
    wr(`DT_OFF_ILRA, 32'h0001_0002);
    rdChk("ilrb", `DT_OFF_ILRB, 32'h0000_0001);
    rdChk("cnta joined", `DT_OFF_CNTA, 32'h0001_0002);
    wr(`DT_OFF_ILRA, 32'h0000_0006);
    wr(`DT_OFF_IMR, 32'h0000_0001);
    wr(`DT_OFF_CTL, 32'h0000_0001);
    waitTrig(1'b0, n);
    chk("oneshot time", 32'h0000_0001, 32'(n < 12));
    rdChk("ris", `DT_OFF_RIS, 32'h0000_0001);
    rdChk("mis", `DT_OFF_MIS, 32'h0000_0001);
    chk("irq set", 32'h0000_0001, {31'h0, irqOut});
    rdChk("ctl cleared", `DT_OFF_CTL, 32'h0000_0000);
    rdChk("reloaded", `DT_OFF_CNTA, 32'h0000_0006);
    wr(`DT_OFF_ICR, 32'h0000_0001);
    rdChk("ris clear", `DT_OFF_RIS, 32'h0000_0000);
    chk("irq clear", 32'h0000_0000, {31'h0, irqOut});
    wr(`DT_OFF_MODEA, 32'h0000_0002);
    wr(`DT_OFF_MODEB, 32'h0000_0001);
    wr(`DT_OFF_ILRA, 32'h0000_0004);
    wr(`DT_OFF_CTL, 32'h0000_0001);
    waitTrig(1'b0, n);
    waitTrig(1'b0, n);
    chk("period", 32'h0000_0005, 32'(n));
    rdChk("ctl running", `DT_OFF_CTL, 32'h0000_0001);
    wr(`DT_OFF_ILRA, 32'h0000_1000);
    wr(`DT_OFF_CTL, 32'h0000_0003);
    dbgHalt <= 1'b1;
    rd(`DT_OFF_CNTA, rv);
    repeat (6) @(posedge sys_clk);
    rd(`DT_OFF_CNTA, rv2);
    chk("frozen", rv, rv2);
    @(posedge sys_clk);
    dbgHalt <= 1'b0;
    rd(`DT_OFF_CNTA, rv2);
    chk("resumed", 32'h0000_0001, 32'(rv2 < rv));
    wr(`DT_OFF_ILRA, 32'h0000_0020);
    rd(`DT_OFF_CNTA, rv);
    chk("new load", 32'h0000_0001, 32'(rv <= 32'h20 && rv > 32'h18));
    wr(`DT_OFF_CTL, 32'h0000_0000);
    wr(`DT_OFF_ICR, 32'h0000_0109);
    wr(`DT_OFF_CFG, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      wr(`DT_OFF_CTL, 32'h0000_0000);
      wr(`DT_OFF_PRB, {24'h0, psTab[i]});
      wr(`DT_OFF_ILRB, {16'h0, ldTab[i]});
      wr(`DT_OFF_MODEB, 32'h0000_0002);
      wr(`DT_OFF_CTL, 32'h0000_0100);
      waitTrig(1'b1, n);
      waitTrig(1'b1, n);
      chk("split period", (ldTab[i] + 1) * (psTab[i] + 1), 32'(n));
    end
    // first half one-shot beside running second half.
    wr(`DT_OFF_PRA, 32'h0000_0001);
    wr(`DT_OFF_ILRA, 32'h0003_0003);
    wr(`DT_OFF_MODEA, 32'h0000_0001);
    wr(`DT_OFF_CTL, 32'h0000_0101);
    waitTrig(1'b0, n);
    chk("split oneshot time", 32'h0000_0009, 32'(n));
    rdChk("split ctl", `DT_OFF_CTL, 32'h0000_0100);
    rdChk("split cnta", `DT_OFF_CNTA, 32'h0000_0003);
    rdChk("split pra", `DT_OFF_PRA, 32'h0000_0001);
    wr(`DT_OFF_CTL, 32'h0000_0000);
    wr(`DT_OFF_ICR, 32'h0000_0109);
    wr(`DT_OFF_CFG, 32'h0000_0001);
    rdChk("rtc first", `DT_OFF_CNTA, 32'h0000_0001);
    wr(`DT_OFF_MATCHA, 32'h0000_0003);
    wr(`DT_OFF_IMR, 32'h0000_0008);
    wr(`DT_OFF_CTL, 32'h0000_0013);
    dbgHalt <= 1'b1;
    rtcOn = 1'b1;
    n = 0;
    do begin
      rd(`DT_OFF_RIS, rv);
      n++;
    end while (rv !== 32'h0000_0008 && n < 400);
    chk("rtc match", 32'h0000_0008, rv);
    rdChk("rtc rolled", `DT_OFF_CNTA, 32'h0000_0000);
    chk("rtc irq", 32'h0000_0001, {31'h0, irqOut});
    wr(`DT_OFF_ICR, 32'h0000_0008);
    rdChk("rtc clear", `DT_OFF_MIS, 32'h0000_0000);
    rtcOn = 1'b0;
    @(posedge sys_clk);
    dbgHalt <= 1'b0;
    endSim();
  end

endmodule
